// *** hw/egmc_main_ctrl.sv ***
// per-group main control for sixteen echo canceller pairs
// assumes pcm and tone events come from logic on aclk; frame_pin is an outside pin
// Notes on behaviour
// - A set canceller-b mask bit keeps canceller b tone events off the interrupt.
// - A set canceller-a mask bit keeps canceller a tone events off the interrupt.
// - The mask only gates the interrupt; tone events are still recorded and reported.
// - The coding bit selects g.711 when set and sign-magnitude when clear, for both cancellers.
// - The law bit selects a-law when set and mu-law when clear, for both cancellers.
// - A set power-up bit makes the group operational; clear puts it in power-down.
// - In power-down, receive and send samples pass through unchanged two frames late.
// - A rising power-up bit issues a pulse that presets canceller registers and coefficients.
// - Initialization lasts two frames and a busy flag shows it so the host can wait.
// - Every tone detect or release sets its status bit and reports its 5-bit channel (lowest-numbered wins); it raises the interrupt only if enabled and unmasked.
`default_nettype none
module egmc_main_ctrl (
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite slave
    input  wire logic [15:0]               awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    input  wire logic [15:0]               araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    // frame sync pin
    input  wire logic                      frame_pin,
    // tone detector events, one-cycle pulses
    input  wire logic [egmc_pkg::NGRP-1:0] tone_evt_a,
    input  wire logic [egmc_pkg::NGRP-1:0] tone_evt_b,
    // pcm paths, channel 2g is canceller a, 2g+1 canceller b
    input  wire egmc_pkg::egmc_pcm_t       pcm_in [egmc_pkg::NCH],
    input  wire egmc_pkg::egmc_pcm_t       ec_out [egmc_pkg::NCH],
    output egmc_pkg::egmc_pcm_t            pcm_out [egmc_pkg::NCH],
    // per-group mode and init
    output egmc_pkg::egmc_mode_t           mode [egmc_pkg::NGRP],
    output logic [egmc_pkg::NGRP-1:0]      init_pulse,
    output logic                           irq
);
    logic [7:0]                ctrl_reg [egmc_pkg::NGRP];
    logic [31:0]               stat_reg;
    logic [31:0]               mask_reg;
    logic [4:0]                chan_reg;
    logic                      aw_full_reg;
    logic                      w_full_reg;
    logic [13:0]               aw_idx_reg;
    logic [31:0]               w_data_reg;
    logic [3:0]                w_strb_reg;
    logic                      do_wr;
    logic [31:0]               byte_msk;
    logic [31:0]               evt;
    logic [31:0]               gate;
    logic [31:0]               stat_next;
    logic [4:0]                chan_next;
    logic [egmc_pkg::NGRP-1:0] busy;
    logic [31:0]               rd_val;
    logic                      rd_hit;
    logic                      fs_s1_reg;
    logic                      fs_s2_reg;
    logic                      fs_s3_reg;
    logic                      frame_tick;
    egmc_pkg::egmc_pcm_t       dl1_reg [egmc_pkg::NCH];
    egmc_pkg::egmc_pcm_t       dl2_reg [egmc_pkg::NCH];

    // write channel capture, address and data in either order
    assign awready = !aw_full_reg;
    assign wready  = !w_full_reg;
    assign do_wr   = aw_full_reg && w_full_reg && !bvalid;
    assign bresp   = egmc_pkg::RESP_OKAY;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_idx_reg  <= 14'h0000;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid      <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_full_reg <= 1'b1;
                aw_idx_reg  <= awaddr[15:2];
            end
            if (wvalid && wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            if (do_wr) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid      <= 1'b1;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    assign byte_msk = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                       {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

    // control registers, one per group
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int g = 0; g < egmc_pkg::NGRP; g++) begin
                ctrl_reg[g] <= egmc_pkg::CTRL_RST;
            end
        end else if (do_wr && w_strb_reg[0]) begin
            for (int g = 0; g < egmc_pkg::NGRP; g++) begin
                if (aw_idx_reg == egmc_pkg::IDX_CTRL0 + 14'(g)) begin
                    ctrl_reg[g] <= w_data_reg[7:0] &
                        ((g == 0) ? egmc_pkg::CTRL0_WMSK : egmc_pkg::CTRLN_WMSK);
                end
            end
        end
    end

    // tone events; recorded whatever the group mask bits say
    always_comb begin
        for (int g = 0; g < egmc_pkg::NGRP; g++) begin
            evt[2*g]    = tone_evt_a[g];
            evt[2*g+1]  = tone_evt_b[g];
            gate[2*g]   = !ctrl_reg[g][egmc_pkg::B_MTA];
            gate[2*g+1] = !ctrl_reg[g][egmc_pkg::B_MTB];
        end
    end

    // sticky status, new events win over a write-one clear
    always_comb begin
        stat_next = stat_reg;
        if (do_wr && aw_idx_reg == egmc_pkg::IDX_STAT) begin
            stat_next = stat_reg & ~(w_data_reg & byte_msk);
        end
        stat_next = stat_next | evt;
    end

    // lowest-numbered channel with a change this cycle
    always_comb begin
        chan_next = chan_reg;
        for (int c = egmc_pkg::NCH - 1; c >= 0; c--) begin
            if (evt[c]) begin
                chan_next = 5'(c);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_reg <= egmc_pkg::STAT_RST;
            chan_reg <= 5'h00;
        end else begin
            stat_reg <= stat_next;
            chan_reg <= chan_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_reg <= egmc_pkg::MASK_RST;
        end else if (do_wr && aw_idx_reg == egmc_pkg::IDX_MASK) begin
            mask_reg <= (mask_reg & ~byte_msk) | (w_data_reg & byte_msk);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_reg & mask_reg & gate);
        end
    end

    // frame pin synchroniser and rising edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fs_s1_reg <= 1'b0;
            fs_s2_reg <= 1'b0;
            fs_s3_reg <= 1'b0;
        end else begin
            fs_s1_reg <= frame_pin;
            fs_s2_reg <= fs_s1_reg;
            fs_s3_reg <= fs_s2_reg;
        end
    end

    assign frame_tick = fs_s2_reg && !fs_s3_reg;

    // per-group power-up sequencing
    for (genvar g = 0; g < egmc_pkg::NGRP; g++) begin : gen_grp
        logic       group_power_up_d_reg;
        logic [1:0] init_cnt_reg;
        logic       group_power_up;

        assign group_power_up = ctrl_reg[g][egmc_pkg::B_GROUP_POWER_UP];

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                group_power_up_d_reg    <= 1'b0;
                init_cnt_reg  <= 2'h0;
                init_pulse[g] <= 1'b0;
            end else begin
                group_power_up_d_reg    <= group_power_up;
                init_pulse[g] <= group_power_up && !group_power_up_d_reg;
                if (group_power_up && !group_power_up_d_reg) begin
                    init_cnt_reg <= egmc_pkg::INIT_FRAMES;
                end else if (!group_power_up) begin
                    init_cnt_reg <= 2'h0;
                end else if (frame_tick && init_cnt_reg != 2'h0) begin
                    init_cnt_reg <= init_cnt_reg - 2'h1;
                end
            end
        end

        assign busy[g] = init_cnt_reg != 2'h0;

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                mode[g] <= '0;
            end else begin
                mode[g].g711      <= ctrl_reg[g][egmc_pkg::B_FMT];
                mode[g].a_law     <= ctrl_reg[g][egmc_pkg::B_LAW];
                mode[g].power_up  <= group_power_up;
                mode[g].init_busy <= busy[g] || (group_power_up && !group_power_up_d_reg);
            end
        end
    end

    // power-down bypass delay line, one stage per frame
    for (genvar c = 0; c < egmc_pkg::NCH; c++) begin : gen_ch
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                dl1_reg[c] <= '0;
                dl2_reg[c] <= '0;
                pcm_out[c] <= '0;
            end else begin
                if (frame_tick) begin
                    dl1_reg[c] <= pcm_in[c];
                    dl2_reg[c] <= dl1_reg[c];
                end
                pcm_out[c] <= ctrl_reg[c/2][egmc_pkg::B_GROUP_POWER_UP] ? ec_out[c] : dl2_reg[c];
            end
        end
    end

    // read path
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        if (araddr[15:2] == egmc_pkg::IDX_STAT) begin
            rd_val = stat_reg;
        end else if (araddr[15:2] == egmc_pkg::IDX_MASK) begin
            rd_val = mask_reg;
        end else if (araddr[15:2] == egmc_pkg::IDX_INFO) begin
            rd_val[4:0] = chan_reg;
            rd_val[egmc_pkg::B_INFO_IRQ] = irq;
            rd_val[egmc_pkg::B_INFO_BUSY +: egmc_pkg::NGRP] = busy;
        end else if (araddr[15:6] == egmc_pkg::IDX_CTRL0[13:4]) begin
            rd_val[7:0] = ctrl_reg[araddr[5:2]];
        end else begin
            rd_hit = 1'b0;
        end
    end

    assign arready = !rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= egmc_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_val;
            rresp  <= rd_hit ? egmc_pkg::RESP_OKAY : egmc_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : egmc_main_ctrl
`default_nettype wire

// *** hw/egmc_pkg.sv ***
// constants and carrier types for the echo group main control block
// assumes a single 50 MHz clock domain and a 32-bit axi4-lite register bus
`default_nettype none
package egmc_pkg;
    localparam int NGRP = 16;
    localparam int NCH  = 32;
    // register word indices; byte address is four times the index
    localparam logic [13:0] IDX_CTRL0 = 14'h0400;
    localparam logic [13:0] IDX_STAT  = 14'h0418;
    localparam logic [13:0] IDX_MASK  = 14'h0419;
    localparam logic [13:0] IDX_INFO  = 14'h041A;
    // control register fields
    localparam int B_GROUP_POWER_UP = 0;
    localparam int B_LAW  = 1;
    localparam int B_FMT  = 2;
    localparam int B_MTA  = 3;
    localparam int B_MTB  = 4;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] CTRL0_WMSK = 8'hFF;
    localparam logic [7:0] CTRLN_WMSK = 8'h1F;
    localparam logic [31:0] STAT_RST  = 32'h0000_0000;
    localparam logic [31:0] MASK_RST  = 32'h0000_0000;
    // info register fields
    localparam int B_INFO_IRQ  = 7;
    localparam int B_INFO_BUSY = 16;
    // frame counts
    localparam logic [1:0] INIT_FRAMES = 2'h2;
    localparam int BYP_FRAMES = 2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] rin;
        logic [7:0] sin;
    } egmc_pcm_t;

    typedef struct packed {
        logic g711;
        logic a_law;
        logic power_up;
        logic init_busy;
    } egmc_mode_t;
endpackage : egmc_pkg
`default_nettype wire

// *** sim/egmc_chk.sv ***
// port assertions for the echo group main control block
// bound into egmc_main_ctrl; watches group 1 and its canceller-a channel
`default_nettype none
module egmc_chk (
    // clock and reset
    input wire logic aclk, aresetn,
    // bus answers
    input wire logic bvalid, bready, rvalid, rready, arready, arvalid,
    input wire logic [1:0] bresp,
    input wire logic [31:0] rdata,
    // pcm, mode and init
    input wire egmc_pkg::egmc_pcm_t ec_out [egmc_pkg::NCH],
    input wire egmc_pkg::egmc_pcm_t pcm_out [egmc_pkg::NCH],
    input wire egmc_pkg::egmc_mode_t mode [egmc_pkg::NGRP],
    input wire logic [egmc_pkg::NGRP-1:0] init_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_pulse;
        init_pulse[1] ##1 !init_pulse[1];
    endsequence
    property p_pulse_one;
        init_pulse[1] |-> s_pulse;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("init pulse too long");
    property p_pulse_busy;
        init_pulse[1] |-> ##[0:1] mode[1].init_busy;
    endproperty
    a_pulse_busy: assert property (p_pulse_busy) else $error("init without busy");
    property p_pulse_pwr;
        init_pulse[1] |-> ##[0:1] mode[1].power_up;
    endproperty
    a_pulse_pwr: assert property (p_pulse_pwr) else $error("init while off");
    property p_up_path;
        mode[1].power_up && $past(mode[1].power_up) |-> pcm_out[2] == $past(ec_out[2]);
    endproperty
    a_up_path: assert property (p_up_path) else $error("canceller path lost");
    property p_bhold;
        bvalid && !bready |=> bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_bresp;
        bvalid |-> bresp == egmc_pkg::RESP_OKAY;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response not okay");
    property p_rhold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_ar_block;
        arvalid && arready |=> rvalid;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken without answer");
endmodule : egmc_chk
bind egmc_main_ctrl egmc_chk u_chk (.aclk(aclk), .aresetn(aresetn), .bvalid(bvalid),
    .bready(bready), .rvalid(rvalid), .rready(rready), .arready(arready), .arvalid(arvalid),
    .bresp(bresp),
    .rdata(rdata), .ec_out(ec_out), .pcm_out(pcm_out), .mode(mode), .init_pulse(init_pulse));
`default_nettype wire

// *** sim/egmc_host.sv ***
// host processor model: axi4-lite master with one write and one read task
// assumes the slave samples on the rising edge of aclk
`default_nettype none
module egmc_host (
    input wire logic aclk,
    output logic [15:0] awaddr, araddr,
    output logic awvalid, wvalid, bready, arvalid, rready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic awready, wready, bvalid, arready, rvalid,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
    end
    // levels at the falling edge equal those sampled at the next rising edge
    // ready is raised only after a response is seen, so the slave must hold it one cycle
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic ta, tw, tv, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tv = bvalid;
            tb = bvalid && bready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tv) bready <= 1'b1;
        end while (!tb);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tv, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ta = arvalid && arready;
            tv = rvalid;
            tr = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tv) rready <= 1'b1;
        end while (!tr);
        rready <= 1'b0;
    endtask : rd
endmodule : egmc_host
`default_nettype wire

// *** sim/test_echo_group_main_control.sv ***
// self-checking bench for the echo group main control block
// assumes egmc_host drives the register bus; frames come from frame_pin
`default_nettype none
module test_echo_group_main_control;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int g; logic [7:0] w; logic [7:0] r;} egmc_row_t;
    logic aclk, aresetn, frame_pin, irq;
    logic [15:0] awaddr, araddr, tone_evt_a, tone_evt_b, init_pulse;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    egmc_pkg::egmc_pcm_t pcm_in [egmc_pkg::NCH], ec_out [egmc_pkg::NCH], pcm_out [egmc_pkg::NCH];
    egmc_pkg::egmc_mode_t mode [egmc_pkg::NGRP];
    int mismatches, total_checks, pulses;
    localparam logic [15:0] INFO = {egmc_pkg::IDX_INFO, 2'b00};
    localparam logic [15:0] STAT = {egmc_pkg::IDX_STAT, 2'b00};
    localparam logic [15:0] MASK = {egmc_pkg::IDX_MASK, 2'b00};
    egmc_row_t rows [5] = '{'{0, 8'hFE, 8'hFE}, '{1, 8'hE0, 8'h00}, '{2, 8'h02, 8'h02},
                           '{3, 8'h04, 8'h04}, '{15, 8'hFE, 8'h1E}};
    egmc_host host (.aclk(aclk), .awaddr(awaddr), .araddr(araddr), .awvalid(awvalid),
        .wvalid(wvalid), .bready(bready), .arvalid(arvalid), .rready(rready), .wdata(wdata),
        .wstrb(wstrb), .awready(awready), .wready(wready), .bvalid(bvalid),
        .arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp));
    egmc_main_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .frame_pin(frame_pin), .tone_evt_a(tone_evt_a), .tone_evt_b(tone_evt_b),
        .pcm_in(pcm_in), .ec_out(ec_out), .pcm_out(pcm_out), .mode(mode),
        .init_pulse(init_pulse), .irq(irq));
    function automatic logic [15:0] ca(input int g);
        return {egmc_pkg::IDX_CTRL0 + 14'(g), 2'b00};
    endfunction : ca
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic frame();
        @(posedge aclk);
        frame_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        frame_pin <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : frame
    task automatic tone(input logic b, input int g);
        @(posedge aclk);
        if (b) tone_evt_b[g] <= 1'b1;
        else tone_evt_a[g] <= 1'b1;
        @(posedge aclk);
        tone_evt_a <= '0;
        tone_evt_b <= '0;
        repeat (3) @(posedge aclk);
    endtask : tone
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(negedge aclk) begin
        if (init_pulse[1] === 1'b1) pulses++;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        close_out();
    end
    initial begin
        {aresetn, frame_pin, tone_evt_a, tone_evt_b} = '0;
        {mismatches, total_checks, pulses} = '0;
        for (int i = 0; i < egmc_pkg::NCH; i++) begin
            pcm_in[i] = '0;
            ec_out[i] = '0;
        end
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        host.rd(ca(0), rv, rs);
        chk(rv, 32'(egmc_pkg::CTRL_RST));
        host.rd(MASK, rv, rs);
        chk(rv, egmc_pkg::MASK_RST);
        foreach (rows[i]) begin
            host.wr(ca(rows[i].g), {24'h0, rows[i].w});
            host.rd(ca(rows[i].g), rv, rs);
            chk(rv, {24'h0, rows[i].r});
            @(negedge aclk);
            chk(32'({mode[rows[i].g].g711, mode[rows[i].g].a_law}), 32'(rows[i].r[2:1]));
        end
        host.rd(16'h0FFC, rv, rs);
        chk(32'(rs), 32'(egmc_pkg::RESP_SLVERR));
        // power-up: one init pulse, busy for two frames, then canceller path
        host.wr(ca(1), 32'h01);
        @(negedge aclk);
        chk(32'(pulses), 32'h1);
        chk(32'(mode[1].init_busy), 32'h1);
        host.wr(ca(1), 32'h01);
        frame();
        host.rd(INFO, rv, rs);
        chk(32'(rv[egmc_pkg::B_INFO_BUSY+1]), 32'h1);
        frame();
        host.rd(INFO, rv, rs);
        chk(32'(rv[egmc_pkg::B_INFO_BUSY+1]), 32'h0);
        chk(32'(pulses), 32'h1);
        ec_out[2] <= 16'h5AA5;
        repeat (3) @(negedge aclk);
        chk(32'(pcm_out[2]), 32'h5AA5);
        // bypass of a powered-down group, two frames late
        pcm_in[6] <= 16'hA55A;
        ec_out[6] <= 16'h3C3C;
        frame();
        pcm_in[6] <= 16'h1234;
        @(negedge aclk);
        chk(32'(pcm_out[6]), 32'h0);
        frame();
        @(negedge aclk);
        chk(32'(pcm_out[6]), 32'hA55A);
        frame();
        @(negedge aclk);
        chk(32'(pcm_out[6]), 32'h1234);
        // interrupt raise, report, clear and per-canceller gating
        host.wr(MASK, 32'h0000_0300);
        tone(1'b0, 4);
        chk(32'(irq), 32'h1);
        host.rd(INFO, rv, rs);
        chk(32'(rv[4:0]), 32'h8);
        host.wr(STAT, 32'h0000_0300);
        @(negedge aclk);
        chk(32'(irq), 32'h0);
        host.wr(ca(4), 32'h08);
        tone(1'b0, 4);
        chk(32'(irq), 32'h0);
        host.rd(STAT, rv, rs);
        chk(rv, 32'h0000_0100);
        tone(1'b1, 4);
        chk(32'(irq), 32'h1);
        host.rd(INFO, rv, rs);
        chk(32'(rv[4:0]), 32'h9);
        chk(32'(rv[egmc_pkg::B_INFO_IRQ]), 32'h1);
        host.wr(ca(4), 32'h18);
        @(negedge aclk);
        chk(32'(irq), 32'h0);
        close_out();
    end
endmodule : test_echo_group_main_control
`default_nettype wire
